// ---- shared/pd_pkg.sv ----
// shared constants for the ddr2 power-down block
package pd_pkg;
  // power-down exit latencies and clock-stop length in link clocks (plain defaults)
  localparam int unsigned EXIT_TXP_CYC    = 2;
  localparam int unsigned EXIT_TXARD_CYC  = 2;
  localparam int unsigned EXIT_TXARDS_CYC = 8;
  localparam int unsigned CLK_STOP_CYC    = 4;
  // mode register bit selecting slow-exit active power-down
  localparam int unsigned MR_SLOW_EXIT_BIT = 12;
  localparam int unsigned MR_WIDTH         = 13;
  localparam int unsigned NUM_BANKS        = 8;
  localparam logic [7:0]  BANKS_IDLE_RST   = 8'h00;
  localparam logic [3:0]  EXIT_CNT_W_INIT  = 4'h0;

  typedef enum logic [2:0] {
    ST_ACTIVE,
    ST_PD_PRE,
    ST_PD_FAST,
    ST_PD_SLOW,
    ST_EXIT
  } pd_state_t;
endpackage

// ---- core/pd_sync.sv ----
// two-flop level synchroniser, one per bit
`timescale 1ns/1ps
module pd_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  // refuse a width the flops cannot hold
  if (WIDTH < 1) begin : g_bad_width
    $error("pd_sync width must be positive");
  end

  // first stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// ---- core/pd_ctrl.sv ----
// ddr2 power-down entry/exit, nop/deselect decode and clock-change tracking
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - enter power-down on cke low with nop/deselect
// - cke low allowed during internal housekeeping
// - all banks idle means precharge power-down
// - mode bit a12 picks fast or slow exit
// - buffers off except clock, odt, cke
// - dll off in precharge and slow-exit
// - exit on cke high, then exit latency
// - nop decoded, no new action
// - nop/deselect never ends running operation
// - cs high is deselect, others ignored
module pd_ctrl #(
  parameter int unsigned TXP_CYC    = pd_pkg::EXIT_TXP_CYC,
  parameter int unsigned TXARD_CYC  = pd_pkg::EXIT_TXARD_CYC,
  parameter int unsigned TXARDS_CYC = pd_pkg::EXIT_TXARDS_CYC,
  parameter int unsigned STOP_CYC   = pd_pkg::CLK_STOP_CYC
) (
  input  wire logic                           clk_sys,
  input  wire logic                           sys_rst,
  input  wire logic                           ck_link,
  input  wire logic                           cke,
  input  wire logic                           cs_n,
  input  wire logic                           ras_n,
  input  wire logic                           cas_n,
  input  wire logic                           we_n,
  input  wire logic                           odt,
  input  wire logic [pd_pkg::MR_WIDTH-1:0]    mode_reg,
  input  wire logic [pd_pkg::NUM_BANKS-1:0]   bank_open,
  input  wire logic                           op_busy,
  output logic                                pd_active,
  output logic                                pd_precharge,
  output logic                                pd_slow_exit,
  output logic                                io_buf_en,
  output logic                                dll_en,
  output logic                                cmd_accept,
  output logic                                cmd_nop,
  output logic                                exit_busy,
  output logic                                async_cke_err,
  output logic                                freq_change_ok,
  output logic                                pd_sys
);
  localparam int unsigned CNT_W = 16;

  // zero latency would still hold the exit state one cycle; too large would wrap the counter
  if (TXP_CYC < 1 || TXARD_CYC < 1 || TXARDS_CYC < 1 || STOP_CYC < 1) begin : g_lat_min
    $error("exit latencies must be at least one cycle");
  end
  if (TXARDS_CYC >= (1 << CNT_W) || TXP_CYC >= (1 << CNT_W) || TXARD_CYC >= (1 << CNT_W)) begin : g_lat_max
    $error("exit latency exceeds counter width");
  end

  pd_pkg::pd_state_t state_r;
  pd_pkg::pd_state_t state_nxt;
  logic [CNT_W-1:0]  exit_cnt_r;
  logic [CNT_W-1:0]  exit_len;
  logic [CNT_W-1:0]  pd_len_r;
  logic              cke_q_r;
  logic              is_nop;
  logic              any_open;
  logic              enter_ok;

  ////////////////////////////////////////////////////////////////////////////
  // command decode on the link clock
  assign is_nop   = cs_n | (ras_n & cas_n & we_n);
  assign any_open = |bank_open;
  // op_busy covers bursts and write recovery; housekeeping does not block
  assign enter_ok = !cke && is_nop && !op_busy;

  // exit latency by mode
  always_comb begin
    case (state_r)
      pd_pkg::ST_PD_FAST: exit_len = CNT_W'(TXARD_CYC);
      pd_pkg::ST_PD_SLOW: exit_len = CNT_W'(TXARDS_CYC);
      default:            exit_len = CNT_W'(TXP_CYC);
    endcase
  end

  // power-down state machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      pd_pkg::ST_ACTIVE: begin
        if (enter_ok) begin
          if (!any_open)
            state_nxt = pd_pkg::ST_PD_PRE;
          else if (mode_reg[pd_pkg::MR_SLOW_EXIT_BIT])
            state_nxt = pd_pkg::ST_PD_SLOW;
          else
            state_nxt = pd_pkg::ST_PD_FAST;
        end
      end
      pd_pkg::ST_PD_PRE, pd_pkg::ST_PD_FAST, pd_pkg::ST_PD_SLOW: begin
        // only cke is watched here; everything else is don't-care
        if (cke)
          state_nxt = pd_pkg::ST_EXIT;
      end
      pd_pkg::ST_EXIT: begin
        if (exit_cnt_r <= CNT_W'(1))
          state_nxt = pd_pkg::ST_ACTIVE;
      end
      default: state_nxt = pd_pkg::ST_ACTIVE;
    endcase
  end

  always_ff @(posedge ck_link or posedge sys_rst) begin
    if (sys_rst)
      state_r <= pd_pkg::ST_ACTIVE;
    else
      state_r <= state_nxt;
  end

  // exit counter loaded at the registering edge of cke high
  always_ff @(posedge ck_link or posedge sys_rst) begin
    if (sys_rst)
      exit_cnt_r <= '0;
    else if (state_r != pd_pkg::ST_EXIT && state_nxt == pd_pkg::ST_EXIT)
      exit_cnt_r <= exit_len;
    else if (exit_cnt_r != '0)
      exit_cnt_r <= exit_cnt_r - CNT_W'(1);
  end

  // mode flags, dll and buffer gating
  always_ff @(posedge ck_link or posedge sys_rst) begin
    if (sys_rst) begin
      pd_active    <= 1'b0;
      pd_precharge <= 1'b0;
      pd_slow_exit <= 1'b0;
      io_buf_en    <= 1'b1;
      dll_en       <= 1'b1;
    end else begin
      pd_active    <= state_nxt inside {pd_pkg::ST_PD_PRE, pd_pkg::ST_PD_FAST, pd_pkg::ST_PD_SLOW};
      pd_precharge <= state_nxt == pd_pkg::ST_PD_PRE;
      pd_slow_exit <= state_nxt == pd_pkg::ST_PD_SLOW;
      io_buf_en    <= !(state_nxt inside {pd_pkg::ST_PD_PRE, pd_pkg::ST_PD_FAST, pd_pkg::ST_PD_SLOW});
      dll_en       <= !(state_nxt inside {pd_pkg::ST_PD_PRE, pd_pkg::ST_PD_SLOW});
    end
  end

  // command acceptance: nops never stop a running operation
  always_ff @(posedge ck_link or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_accept <= 1'b0;
      cmd_nop    <= 1'b0;
    end else begin
      cmd_accept <= (state_r == pd_pkg::ST_ACTIVE) && cke && cke_q_r && !is_nop;
      cmd_nop    <= (state_r == pd_pkg::ST_ACTIVE) && cke && is_nop;
    end
  end

  assign exit_busy = (state_r == pd_pkg::ST_EXIT);

  // cke falling outside a legal entry flags async loss
  always_ff @(posedge ck_link or posedge sys_rst) begin
    if (sys_rst) begin
      cke_q_r       <= 1'b1;
      async_cke_err <= 1'b0;
    end else begin
      cke_q_r <= cke;
      if (state_r == pd_pkg::ST_ACTIVE && !cke && cke_q_r && (!is_nop || op_busy))
        async_cke_err <= 1'b1;
    end
  end

  // clock change window: precharge pd, odt off, two clocks after entry
  always_ff @(posedge ck_link or posedge sys_rst) begin
    if (sys_rst) begin
      pd_len_r       <= '0;
      freq_change_ok <= 1'b0;
    end else begin
      if (state_r == pd_pkg::ST_PD_PRE && pd_len_r != '1)
        pd_len_r <= pd_len_r + CNT_W'(1);
      else if (state_r != pd_pkg::ST_PD_PRE)
        pd_len_r <= '0;
      freq_change_ok <= (state_r == pd_pkg::ST_PD_PRE) && !odt && !cke && (pd_len_r >= CNT_W'(1));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-down level handed to the system clock domain
  pd_sync #(
    .WIDTH (1)
  ) u_pd_sync (
    .clk (clk_sys),
    .rst (sys_rst),
    .d   (pd_active),
    .q   (pd_sys)
  );
endmodule

// ---- sim/pd_ctrl_properties.sv ----
// concurrent checks of the power-down block, seen from its ports
`timescale 1ns/1ps
module pd_ctrl_properties (
  input wire logic                         ck_link, sys_rst, cke, cs_n, ras_n, cas_n, we_n, op_busy,
  input wire logic [pd_pkg::MR_WIDTH-1:0]  mode_reg,
  input wire logic [pd_pkg::NUM_BANKS-1:0] bank_open,
  input wire logic                         pd_active, pd_precharge, pd_slow_exit, io_buf_en,
  input wire logic                         dll_en, cmd_accept, cmd_nop, exit_busy
);
  default clocking @(posedge ck_link); endclocking
  default disable iff (sys_rst);
  // running state and quiet command, shared by several checks
  wire idle = !pd_active && !exit_busy;
  wire quiet = cs_n || (ras_n && cas_n && we_n);
  ////////////////////////////////////////////////////////////////////////////////
  pd_entry_a: assert property (idle && $past(cke) && !cke && quiet && !op_busy |=> pd_active)
    else $error("power-down not entered");
  pd_class_a: assert property ($rose(pd_active) |-> pd_precharge == ($past(bank_open) == '0))
    else $error("power-down kind wrong");
  slow_select_a: assert property ($rose(pd_active) && !pd_precharge |->
    pd_slow_exit == $past(mode_reg[pd_pkg::MR_SLOW_EXIT_BIT])) else $error("exit speed wrong");
  buf_off_a: assert property (pd_active |-> !io_buf_en && !cmd_accept) else $error("buffers on");
  dll_mode_a: assert property (pd_active |-> dll_en == !(pd_precharge || pd_slow_exit))
    else $error("dll state wrong");
  pd_hold_a: assert property (pd_active && !cke |=> pd_active) else $error("left power-down");
  pd_exit_a: assert property (pd_active && cke |=> !pd_active && exit_busy) else $error("no exit");
  exit_latency_a: assert property (pd_precharge && cke |=> exit_busy [*2] ##1 !exit_busy)
    else $error("precharge exit latency wrong");
  slow_latency_a: assert property (pd_slow_exit && cke |=> exit_busy [*8] ##1 !exit_busy)
    else $error("slow exit latency wrong");
  nop_decode_a: assert property (idle && cke && $past(cke) && !$past(sys_rst) && quiet |=>
    cmd_nop && !cmd_accept) else $error("nop decode wrong");
  // main scenarios reached
  cover property ($rose(pd_active) && pd_precharge);
  cover property ($rose(pd_active) && pd_slow_exit);
  cover property ($fell(exit_busy));
endmodule
bind pd_ctrl pd_ctrl_properties chk (.ck_link(ck_link), .sys_rst(sys_rst), .cke(cke), .cs_n(cs_n),
  .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .op_busy(op_busy), .mode_reg(mode_reg), .bank_open(bank_open),
  .pd_active(pd_active), .pd_precharge(pd_precharge), .pd_slow_exit(pd_slow_exit), .io_buf_en(io_buf_en),
  .dll_en(dll_en), .cmd_accept(cmd_accept), .cmd_nop(cmd_nop), .exit_busy(exit_busy));

// ---- sim/mem_ctl_model.sv ----
// link-side controller model: makes the memory clock and drives the command pins
`timescale 1ns/1ps
module mem_ctl_model (
  output logic ck_link,
  output logic cke, cs_n, ras_n, cas_n, we_n, odt, op_busy
);
  // half period; only changed while in precharge power-down with odt low
  real hp = 15.0;
  initial ck_link = 1'b0;
  // odt never raised and dll taken as locked; power-down stays far below refresh limits
  initial {cke, cs_n, ras_n, cas_n, we_n, odt, op_busy} = 7'h7c;
  always #(hp) ck_link = ~ck_link;
  // one command a clock, launched on the falling edge; no burst ever runs here
  task cyc(input logic k, input logic [3:0] c);
    @(negedge ck_link);
    cke <= k;
    {cs_n, ras_n, cas_n, we_n} <= c;
  endtask
endmodule

// ---- sim/tb_pd_ctrl.sv ----
// self-checking bench for the ddr2 power-down block
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; $display("FAIL %s exp %h got %h", n, e, a); end end
module tb_pd_ctrl;
  logic                           clk_sys = 1'b0;
  logic                           sys_rst = 1'b1;
  logic [pd_pkg::MR_WIDTH-1:0]    mode_reg = '0;
  logic [pd_pkg::NUM_BANKS-1:0]   bank_open = '0;
  logic                           ck_link, cke, cs_n, ras_n, cas_n, we_n, odt, op_busy;
  logic                           pd_active, pd_precharge, pd_slow_exit, io_buf_en, dll_en, cmd_accept;
  logic                           cmd_nop, exit_busy, async_cke_err, freq_change_ok, pd_sys;
  int                             n_tests = 0, n_mismatch = 0, seed = 28750, lat = 0, el, nb;
  logic [3:0]                     qf[$], ef;
  int                             ql[$];
  logic                           pd_q = 1'b0;
  always #4 clk_sys = ~clk_sys;
  mem_ctl_model ctl (.ck_link(ck_link), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .odt(odt), .op_busy(op_busy));
  pd_ctrl dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .ck_link(ck_link), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .odt(odt), .mode_reg(mode_reg), .bank_open(bank_open), .op_busy(op_busy),
    .pd_active(pd_active), .pd_precharge(pd_precharge), .pd_slow_exit(pd_slow_exit), .io_buf_en(io_buf_en),
    .dll_en(dll_en), .cmd_accept(cmd_accept), .cmd_nop(cmd_nop), .exit_busy(exit_busy),
    .async_cke_err(async_cke_err), .freq_change_ok(freq_change_ok), .pd_sys(pd_sys));
  task close_out;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // monitor: flags when power-down starts, latency once the exit wait ends
  always @(posedge ck_link) begin
    #1;
    if (pd_active === 1'b1 && !pd_q && qf.size() > 0) begin
      ef = qf.pop_front();
      `CHK("pd flags", ef, {pd_precharge, pd_slow_exit, dll_en, io_buf_en})
    end
    if (exit_busy === 1'b1) lat++;
    else if (lat > 0 && ql.size() > 0) begin
      el = ql.pop_front();
      `CHK("exit latency", el, lat)
      lat = 0;
    end
    pd_q = (pd_active === 1'b1);
  end
  // hang guard
  initial begin
    #100us;
    n_mismatch++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(negedge clk_sys);
    sys_rst = 1'b0;
    // precharge, fast-exit and slow-exit power-down in turn
    for (int m = 0; m < 3; m++) begin
      ctl.cyc(1'b1, 4'h7);
      mode_reg = 13'($random(seed));
      mode_reg[pd_pkg::MR_SLOW_EXIT_BIT] = (m == 2);
      nb = $random(seed);
      bank_open = (m == 0) ? 8'h00 : (8'h01 << nb[2:0]) | 8'(nb);
      qf.push_back(m == 0 ? 4'h8 : (m == 1 ? 4'h2 : 4'h4));
      ql.push_back(m == 2 ? 8 : 2);
      ctl.cyc(1'b1, 4'h7);
      ctl.cyc(1'b0, m == 1 ? {1'b1, 3'($random(seed))} : 4'h7);
      repeat (4) ctl.cyc(1'b0, 4'($random(seed)));
      `CHK("pd crossed", 1'b1, pd_sys)
      if (m == 0) begin
        `CHK("freq change ok", 1'b1, freq_change_ok)
        ctl.hp = 20.0;
        repeat (3) ctl.cyc(1'b0, 4'h7);
        ctl.hp = 15.0;
        repeat (2) ctl.cyc(1'b0, 4'h7);
      end
      ctl.cyc(1'b1, 4'h8);
      repeat (10) ctl.cyc(1'b1, 4'h7);
      $display("power-down mode %0d done", m);
    end
    // executable command taken, then clock enable dropped under it
    ctl.cyc(1'b1, 4'h3);
    ctl.cyc(1'b1, 4'h7);
    `CHK("cmd accept", 1'b1, cmd_accept)
    `CHK("cmd nop", 1'b0, cmd_nop)
    ctl.cyc(1'b0, 4'h3);
    repeat (2) ctl.cyc(1'b0, 4'h7);
    `CHK("async drop", 1'b1, async_cke_err)
    sys_rst = 1'b1;
    repeat (6) @(negedge clk_sys);
    @(negedge ck_link);
    sys_rst = 1'b0;
    `CHK("reinit clears", 1'b0, async_cke_err)
    $display("clock enable drop done");
    for (int i = 0; i < 20 && qf.size() + ql.size() > 0; i++) @(posedge ck_link);
    if (qf.size() + ql.size() > 0) n_mismatch++;
    close_out();
  end
endmodule
